// file: inc/cor_map.svh
`ifndef COR_MAP_SVH
`define COR_MAP_SVH

// ****************************************
// Device register offsets
// ****************************************
`define COR_OPT_ADDR 8'h12
`define COR_CUR_ADDR 8'h14
`define COR_STAT_ADDR 8'h21
`define COR_HOT_ADDR 8'h34
`define COR_SENSE_ADDR 8'h40

// ****************************************
// Reset values
// ****************************************
`define COR_OPT_RESET 16'he70e
`define COR_CUR_RESET 7'h00
`define COR_WORD_ZERO 16'h0000

// ****************************************
// Field positions
// ****************************************
`define COR_AUTO_OFF_BIT 12
`define COR_CMP_LATCH_BIT 7
`define COR_UVP_DIS_BIT 6
`define COR_CALIB_BIT 5
`define COR_IN_GAIN_BIT 4
`define COR_BAT_GAIN_BIT 3
`define COR_LDO_BIT 2
`define COR_IN_LOOP_BIT 1
`define COR_INHIBIT_BIT 0
`define COR_CUR_MSB 12
`define COR_CUR_LSB 6
`define COR_CUR_BAD_MSB 15
`define COR_CUR_BAD_LSB 13
`define COR_STAT_CMP_BIT 6
`define COR_HOT_LATCH_BIT 6
`define COR_SENSE_HALF_BIT 0

// ****************************************
// Pre-charge clamps in mA
// ****************************************
`define COR_CLAMP_LOW_MA 384
`define COR_CLAMP_HIGH_MA 2000

// ****************************************
// Host controller offsets and fields
// ****************************************
`define COR_H_TARGET 4'h0
`define COR_H_DATA 4'h1
`define COR_H_GO 4'h2
`define COR_H_STATUS 4'h3
`define COR_H_RESULT 4'h4
`define COR_H_GO_READ_BIT 0

`endif

// file: inc/cor_pkg.sv
package cor_pkg;
    typedef logic [7:0] cor_addr_type;
    typedef logic [15:0] cor_word_type;
    typedef logic [3:0] cor_sw_addr_type;
    typedef logic [13:0] cor_ma_type;
    typedef enum logic [2:0] {
        COR_IDLE = 3'b001,
        COR_ISSUE = 3'b010,
        COR_CAPTURE = 3'b100
    } cor_state_type;
endpackage

// file: inc/cor_reg_if.sv
interface cor_reg_if;
    import cor_pkg::*;
    cor_addr_type addr;
    cor_word_type wdata;
    logic wr;
    logic rd;
    cor_word_type rdata;

    modport device (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata
    );

    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata
    );
endinterface

// file: tb/charger_option_and_current_regs_tb.sv
`include "cor_map.svh"

module charger_option_and_current_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cor_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    cor_sw_addr_type sw_addr = 4'h0;
    cor_word_type sw_wdata = 16'h0000;
    logic sw_wr = 1'b0, sw_rd = 1'b0;
    cor_word_type sw_rdata;
    logic comparator_raw = 1'b1, battery_present_pin = 1'b1, adapter_valid_flag = 1'b1;
    logic register_reset_req = 1'b0, charge_voltage_zero_write = 1'b0, watchdog_expired = 1'b0;
    logic single_cell = 1'b0, vbat_below_3v0 = 1'b0, vbat_below_min = 1'b0;
    logic comparator_output_pin, comparator_status, system_uvp_active, calib_discharge;
    logic converter_off, input_amp_gain_40x, battery_amp_gain_16x, battery_switch_full_on;
    logic regulate_from_max_voltage, input_loop_active, charging_enable;
    cor_ma_type charge_current_ma, charge_target_ma;
    int bad_count = 0;
    int compares = 0;

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    // ****
    // Design and monitor
    // ****
    cor_reg_if bus_if ();
    cor_host u_cor_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_if), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    cor_device u_cor_device (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_if),
        .comparator_raw(comparator_raw), .battery_present_pin(battery_present_pin),
        .adapter_valid_flag(adapter_valid_flag), .register_reset_req(register_reset_req),
        .charge_voltage_zero_write(charge_voltage_zero_write),
        .watchdog_expired(watchdog_expired), .single_cell(single_cell),
        .vbat_below_3v0(vbat_below_3v0), .vbat_below_min(vbat_below_min),
        .comparator_output_pin(comparator_output_pin), .comparator_status(comparator_status),
        .system_uvp_active(system_uvp_active), .calib_discharge(calib_discharge),
        .converter_off(converter_off), .input_amp_gain_40x(input_amp_gain_40x),
        .battery_amp_gain_16x(battery_amp_gain_16x),
        .battery_switch_full_on(battery_switch_full_on),
        .regulate_from_max_voltage(regulate_from_max_voltage),
        .input_loop_active(input_loop_active), .charging_enable(charging_enable),
        .charge_current_ma(charge_current_ma), .charge_target_ma(charge_target_ma));
    cor_bus_monitor u_cor_bus_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));

    // ****
    // Shared tasks
    // ****
    task automatic tally_and_finish();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic compare_word(input cor_word_type seen, input cor_word_type exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp);
        compare_word({15'h0000, seen}, {15'h0000, exp});
    endtask

    task automatic sw_cycle(input logic is_rd, input cor_sw_addr_type a, input cor_word_type d,
        output cor_word_type q);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= !is_rd;
        sw_rd <= is_rd;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        #1 q = sw_rdata;
    endtask

    // Device access via the host, busy poll bounded
    task automatic dev(input logic is_rd, input cor_addr_type a, input cor_word_type d,
        output cor_word_type q);
        cor_word_type s;
        sw_cycle(1'b0, `COR_H_TARGET, {8'h00, a}, s);
        sw_cycle(1'b0, `COR_H_DATA, d, s);
        sw_cycle(1'b0, `COR_H_GO, {15'h0000, is_rd}, s);
        s = 16'h0001;
        for (int n = 0; s[0] !== 1'b0; n++) begin
            if (n > 20) begin
                bad_count++;
                tally_and_finish();
            end
            sw_cycle(1'b1, `COR_H_STATUS, 16'h0000, s);
        end
        sw_cycle(1'b1, `COR_H_RESULT, 16'h0000, q);
    endtask

    task automatic wr_reg(input cor_addr_type a, input cor_word_type d);
        cor_word_type s;
        dev(1'b0, a, d, s);
    endtask

    task automatic rd_chk(input cor_addr_type a, input cor_word_type exp);
        cor_word_type q;
        dev(1'b1, a, 16'h0000, q);
        compare_word(q, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rd_chk(`COR_OPT_ADDR, `COR_OPT_RESET);
        rd_chk(`COR_CUR_ADDR, 16'h0000);
        rd_chk(8'h13, 16'h0000);
        chk1(system_uvp_active, 1'b1);
        chk1(input_amp_gain_40x, 1'b0);
        chk1(battery_amp_gain_16x, 1'b1);
        chk1(input_loop_active, 1'b1);
        chk1(charging_enable, 1'b0);
    endtask

    task automatic t_option();
        wr_reg(`COR_OPT_ADDR, 16'he7f1);
        rd_chk(`COR_OPT_ADDR, 16'he7f1);
        chk1(system_uvp_active, 1'b0);
        chk1(calib_discharge, 1'b1);
        chk1(converter_off, 1'b1);
        chk1(input_amp_gain_40x, 1'b1);
        chk1(battery_amp_gain_16x, 1'b0);
        chk1(input_loop_active, 1'b0);
        wr_reg(`COR_OPT_ADDR, `COR_OPT_RESET);
        chk1(calib_discharge, 1'b0);
        chk1(converter_off, 1'b0);
    endtask

    task automatic t_current();
        for (int i = 6; i <= 12; i++) begin
            wr_reg(`COR_CUR_ADDR, (16'h0001 << i) | 16'h003f);
            rd_chk(`COR_CUR_ADDR, 16'h0001 << i);
            compare_word({2'h0, charge_current_ma}, 16'h0040 << (i - 6));
        end
        wr_reg(`COR_CUR_ADDR, 16'h1fc0);
        compare_word({2'h0, charge_current_ma}, 16'h1fc0);
        chk1(charging_enable, 1'b1);
        wr_reg(`COR_OPT_ADDR, 16'he70f);
        chk1(charging_enable, 1'b0);
        wr_reg(`COR_OPT_ADDR, `COR_OPT_RESET);
        for (int b = 13; b <= 15; b++) begin
            wr_reg(`COR_CUR_ADDR, (16'h0001 << b) | 16'h0140);
            rd_chk(`COR_CUR_ADDR, 16'h1fc0);
        end
        compare_word({2'h0, charge_current_ma}, 16'h1fc0);
        wr_reg(`COR_SENSE_ADDR, 16'h0001);
        wr_reg(`COR_CUR_ADDR, 16'h0140);
        compare_word({2'h0, charge_current_ma}, 16'h0280);
        wr_reg(`COR_SENSE_ADDR, 16'h0000);
        compare_word({2'h0, charge_current_ma}, 16'h0140);
    endtask

    task automatic t_zero();
        for (int e = 0; e < 5; e++) begin
            wr_reg(`COR_CUR_ADDR, 16'h0140);
            @(posedge ref_clk);
            case (e)
                0: battery_present_pin <= 1'b0;
                1: adapter_valid_flag <= 1'b0;
                2: register_reset_req <= 1'b1;
                3: charge_voltage_zero_write <= 1'b1;
                default: watchdog_expired <= 1'b1;
            endcase
            @(posedge ref_clk);
            {battery_present_pin, adapter_valid_flag} <= 2'h3;
            {register_reset_req, charge_voltage_zero_write, watchdog_expired} <= 3'h0;
            rd_chk(`COR_CUR_ADDR, 16'h0000);
        end
        wr_reg(`COR_OPT_ADDR, 16'hf70e);
        @(posedge ref_clk);
        battery_present_pin <= 1'b0;
        @(posedge ref_clk);
        battery_present_pin <= 1'b1;
        rd_chk(`COR_OPT_ADDR, 16'hf70c);
        chk1(input_loop_active, 1'b0);
        wr_reg(`COR_OPT_ADDR, 16'hf70e);
        chk1(input_loop_active, 1'b1);
        wr_reg(`COR_OPT_ADDR, `COR_OPT_RESET);
    endtask

    task automatic t_precharge();
        wr_reg(`COR_CUR_ADDR, 16'h1fc0);
        @(posedge ref_clk);
        vbat_below_min <= 1'b1;
        settle();
        compare_word({2'h0, charge_target_ma}, 16'h0180);
        @(posedge ref_clk);
        single_cell <= 1'b1;
        settle();
        compare_word({2'h0, charge_target_ma}, 16'h07d0);
        @(posedge ref_clk);
        vbat_below_3v0 <= 1'b1;
        settle();
        compare_word({2'h0, charge_target_ma}, 16'h0180);
        wr_reg(`COR_OPT_ADDR, 16'he70a);
        chk1(battery_switch_full_on, 1'b1);
        chk1(regulate_from_max_voltage, 1'b1);
        wr_reg(`COR_OPT_ADDR, `COR_OPT_RESET);
        @(posedge ref_clk);
        vbat_below_min <= 1'b0;
        single_cell <= 1'b0;
        vbat_below_3v0 <= 1'b0;
    endtask

    task automatic t_comparator();
        wr_reg(`COR_HOT_ADDR, 16'h0040);
        wr_reg(`COR_OPT_ADDR, 16'he78e);
        @(posedge ref_clk);
        comparator_raw <= 1'b0;
        repeat (3) @(posedge ref_clk);
        comparator_raw <= 1'b1;
        settle();
        chk1(comparator_output_pin, 1'b0);
        chk1(comparator_status, 1'b1);
        rd_chk(`COR_STAT_ADDR, 16'h0040);
        rd_chk(`COR_STAT_ADDR, 16'h0000);
        chk1(comparator_status, 1'b0);
        wr_reg(`COR_OPT_ADDR, `COR_OPT_RESET);
        chk1(comparator_output_pin, 1'b1);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_option();
        t_current();
        t_zero();
        t_precharge();
        t_comparator();
        tally_and_finish();
    end
endmodule // charger_option_and_current_regs_tb

// file: tb/cor_bus_monitor.sv
`include "cor_map.svh"

module cor_bus_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input cor_pkg::cor_addr_type addr,
    input cor_pkg::cor_word_type wdata,
    input wire logic wr,
    input wire logic rd,
    input cor_pkg::cor_word_type rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import cor_pkg::*;

    // ****
    // Written-since-reset flags
    // ****
    logic opt_wr_q, cur_wr_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_wr_q <= 1'b0;
            cur_wr_q <= 1'b0;
        end else if (wr) begin
            opt_wr_q <= opt_wr_q | (addr == `COR_OPT_ADDR);
            cur_wr_q <= cur_wr_q | (addr == `COR_CUR_ADDR);
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ****
    // Bus protocol
    // ****
    strobe_excl_a: assert property (!(wr && rd))
        else $error("strobes overlap");
    wr_single_a: assert property (wr |=> !wr)
        else $error("long write strobe");
    rd_single_a: assert property (rd |=> !rd)
        else $error("long read strobe");
    rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
        else $error("stale read data");

    // ****
    // Register contents
    // ****
    opt_reset_a: assert property (
        rd && addr == `COR_OPT_ADDR && !opt_wr_q |=> rdata == `COR_OPT_RESET)
        else $error("option reset value wrong");
    cur_reset_a: assert property (
        rd && addr == `COR_CUR_ADDR && !cur_wr_q |=> rdata == 16'h0000)
        else $error("current reset not zero");
    cur_fields_a: assert property (
        rd && addr == `COR_CUR_ADDR |=> rdata[15:13] == 3'h0 && rdata[5:0] == 6'h00)
        else $error("current unused bits set");
    unmapped_zero_a: assert property (
        rd && addr != `COR_OPT_ADDR && addr != `COR_CUR_ADDR && addr != `COR_STAT_ADDR
        && addr != `COR_HOT_ADDR && addr != `COR_SENSE_ADDR |=> rdata == 16'h0000)
        else $error("unmapped read not zero");

    bad_write_c: cover property (wr && addr == `COR_CUR_ADDR && wdata[15:13] != 3'h0);
    stat_read_c: cover property (rd && addr == `COR_STAT_ADDR);
    opt_write_c: cover property (wr && addr == `COR_OPT_ADDR);
endmodule // cor_bus_monitor

// file: verilog/cor_comparator_latch.sv
`include "cor_map.svh"

module cor_comparator_latch (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic comparator_raw,
    input wire logic latch_enable,
    input wire logic hot_latch_enable,
    input wire logic status_read,
    output logic comparator_output_pin,
    output logic status_flag
);
    import cor_pkg::*;

    // ****************************************
    // Output pin: low sticks while latching is on
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            comparator_output_pin <= 1'b1;
        end else if (latch_enable) begin
            comparator_output_pin <= comparator_output_pin & comparator_raw;
        end else begin
            comparator_output_pin <= comparator_raw;
        end
    end

    // ****************************************
    // Status flag: sticky until read while hot latch is on, a trip beats the read
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_flag <= 1'b0;
        end else begin
            status_flag <= !comparator_raw
                | (hot_latch_enable & status_flag & !status_read);
        end
    end
endmodule // cor_comparator_latch

// file: verilog/cor_device.sv
// What this block does
// - Latched comparator stays low; toggling bit clears
// - Hot-profile latch keeps status until read
// - Undervoltage disable bit zero keeps protection on
// - Calibration bit discharges battery, converter off
// - Input amp gain 20x at zero, 40x one
// - Battery amp gain 8x zero, 16x default
// - No linear mode, battery below minimum: switch on, max-voltage regulation
// - Linear pre-charge clamps to 384 mA or 2 A
// - Host sets loop enable; auto-off clears it
// - Inhibit bit one blocks charging, zero allows
// - Charge current 0 to 8.128 A, 64 mA
// - Charge current zero after power-on reset
// - Battery, adapter, reset, 0 V, watchdog zero current
// - Converter faults leave charge current alone
// - Bits 12..8 weigh 4096 down to 256 mA
// - Any of bits 15..13 set: invalid write
// - 10 milliohm default; 5 milliohm doubles steps
// - Bits 7, 6 weigh 128, 64 mA; rest ignored
//
// The plain strobed port was chosen for this implementation.
`include "cor_map.svh"

module cor_device #(
    parameter int CLAMP_LOW_MA = `COR_CLAMP_LOW_MA,
    parameter int CLAMP_HIGH_MA = `COR_CLAMP_HIGH_MA
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    cor_reg_if.device bus,
    input wire logic comparator_raw,
    input wire logic battery_present_pin,
    input wire logic adapter_valid_flag,
    input wire logic register_reset_req,
    input wire logic charge_voltage_zero_write,
    input wire logic watchdog_expired,
    input wire logic single_cell,
    input wire logic vbat_below_3v0,
    input wire logic vbat_below_min,
    output logic comparator_output_pin,
    output logic comparator_status,
    output logic system_uvp_active,
    output logic calib_discharge,
    output logic converter_off,
    output logic input_amp_gain_40x,
    output logic battery_amp_gain_16x,
    output logic battery_switch_full_on,
    output logic regulate_from_max_voltage,
    output logic input_loop_active,
    output logic charging_enable,
    output cor_pkg::cor_ma_type charge_current_ma,
    output cor_pkg::cor_ma_type charge_target_ma
);
    import cor_pkg::*;

    // ****************************************
    // Parameter checks
    // ****************************************
    if (CLAMP_LOW_MA <= 0 || CLAMP_LOW_MA >= (1 << $bits(cor_ma_type))) begin : g_bad_low
        $error("CLAMP_LOW_MA out of range");
    end
    if (CLAMP_HIGH_MA <= 0 || CLAMP_HIGH_MA >= (1 << $bits(cor_ma_type))) begin : g_bad_high
        $error("CLAMP_HIGH_MA out of range");
    end

    localparam cor_ma_type LOW_MA = cor_ma_type'(CLAMP_LOW_MA);
    localparam cor_ma_type HIGH_MA = cor_ma_type'(CLAMP_HIGH_MA);

    function automatic logic hit(input logic strobe, input cor_addr_type a,
                                 input cor_addr_type key);
        return strobe && (a == key);
    endfunction

    cor_word_type opt_q;
    cor_word_type opt_d;
    logic [`COR_CUR_MSB-`COR_CUR_LSB:0] cur_q;
    logic [`COR_CUR_MSB-`COR_CUR_LSB:0] cur_d;
    logic hot_latch_q;
    logic sense_half_q;
    logic bat_prev_q;
    logic bat_fall;
    logic cur_zero_req;
    logic cur_write_ok;
    logic [12:0] cur_ma;
    cor_ma_type scaled_ma;
    cor_ma_type clamp_ma;
    cor_ma_type target_ma;

    // ****************************************
    // Event detection
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bat_prev_q <= 1'b1;
        end else begin
            bat_prev_q <= battery_present_pin;
        end
    end

    assign bat_fall = bat_prev_q & !battery_present_pin;
    // Converter faults are not inputs here, so they cannot disturb the setting
    assign cur_zero_req = bat_fall | !adapter_valid_flag | register_reset_req
        | charge_voltage_zero_write | watchdog_expired;
    assign cur_write_ok = hit(bus.wr, bus.addr, `COR_CUR_ADDR)
        && (bus.wdata[`COR_CUR_BAD_MSB:`COR_CUR_BAD_LSB] == 3'h0);

    // ****************************************
    // Option register
    // ****************************************
    always_comb begin
        opt_d = opt_q;
        if (register_reset_req) begin
            opt_d = `COR_OPT_RESET;
        end else begin
            if (hit(bus.wr, bus.addr, `COR_OPT_ADDR)) begin
                opt_d = bus.wdata;
            end
            if (bat_fall && opt_q[`COR_AUTO_OFF_BIT]) begin
                opt_d[`COR_IN_LOOP_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_q <= `COR_OPT_RESET;
        end else begin
            opt_q <= opt_d;
        end
    end

    // ****************************************
    // Charge current register
    // ****************************************
    always_comb begin
        cur_d = cur_q;
        if (cur_zero_req) begin
            cur_d = `COR_CUR_RESET;
        end else if (cur_write_ok) begin
            cur_d = bus.wdata[`COR_CUR_MSB:`COR_CUR_LSB];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= `COR_CUR_RESET;
        end else begin
            cur_q <= cur_d;
        end
    end

    // ****************************************
    // Hot-profile latch and sense resistor select
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hot_latch_q <= 1'b0;
            sense_half_q <= 1'b0;
        end else if (register_reset_req) begin
            hot_latch_q <= 1'b0;
            sense_half_q <= 1'b0;
        end else begin
            if (hit(bus.wr, bus.addr, `COR_HOT_ADDR)) begin
                hot_latch_q <= bus.wdata[`COR_HOT_LATCH_BIT];
            end
            if (hit(bus.wr, bus.addr, `COR_SENSE_ADDR)) begin
                sense_half_q <= bus.wdata[`COR_SENSE_HALF_BIT];
            end
        end
    end

    // ****************************************
    // Comparator
    // ****************************************
    cor_comparator_latch u_cmp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .comparator_raw(comparator_raw),
        .latch_enable(opt_q[`COR_CMP_LATCH_BIT]),
        .hot_latch_enable(hot_latch_q),
        .status_read(hit(bus.rd, bus.addr, `COR_STAT_ADDR)),
        .comparator_output_pin(comparator_output_pin),
        .status_flag(comparator_status)
    );

    // ****************************************
    // Current arithmetic
    // ****************************************
    // Bit 6 weighs 64 mA, so the field padded with six zeros is the mA value
    assign cur_ma = {cur_q, 6'h00};
    assign scaled_ma = sense_half_q ? {cur_ma, 1'b0} : {1'b0, cur_ma};
    assign clamp_ma = (single_cell && !vbat_below_3v0) ? HIGH_MA : LOW_MA;

    always_comb begin
        target_ma = scaled_ma;
        if (opt_q[`COR_LDO_BIT] && vbat_below_min && scaled_ma > clamp_ma) begin
            target_ma = clamp_ma;
        end
    end

    // ****************************************
    // Control outputs
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            system_uvp_active <= 1'b1;
            calib_discharge <= 1'b0;
            converter_off <= 1'b0;
            input_amp_gain_40x <= 1'b0;
            battery_amp_gain_16x <= 1'b1;
            battery_switch_full_on <= 1'b0;
            regulate_from_max_voltage <= 1'b0;
            input_loop_active <= 1'b1;
            charging_enable <= 1'b0;
            charge_current_ma <= '0;
            charge_target_ma <= '0;
        end else begin
            system_uvp_active <= !opt_q[`COR_UVP_DIS_BIT];
            calib_discharge <= opt_q[`COR_CALIB_BIT];
            converter_off <= opt_q[`COR_CALIB_BIT];
            input_amp_gain_40x <= opt_q[`COR_IN_GAIN_BIT];
            battery_amp_gain_16x <= opt_q[`COR_BAT_GAIN_BIT];
            battery_switch_full_on <= !opt_q[`COR_LDO_BIT] && vbat_below_min;
            regulate_from_max_voltage <= !opt_q[`COR_LDO_BIT] && vbat_below_min;
            input_loop_active <= opt_q[`COR_IN_LOOP_BIT];
            charging_enable <= !opt_q[`COR_INHIBIT_BIT] && adapter_valid_flag
                && (cur_q != `COR_CUR_RESET) && !opt_q[`COR_CALIB_BIT];
            charge_current_ma <= scaled_ma;
            charge_target_ma <= target_ma;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.rdata <= `COR_WORD_ZERO;
        end else begin
            bus.rdata <= `COR_WORD_ZERO;
            if (bus.rd) begin
                case (bus.addr)
                    `COR_OPT_ADDR: begin
                        bus.rdata <= opt_q;
                    end
                    `COR_CUR_ADDR: begin
                        bus.rdata[`COR_CUR_MSB:`COR_CUR_LSB] <= cur_q;
                    end
                    `COR_STAT_ADDR: begin
                        bus.rdata[`COR_STAT_CMP_BIT] <= comparator_status;
                    end
                    `COR_HOT_ADDR: begin
                        bus.rdata[`COR_HOT_LATCH_BIT] <= hot_latch_q;
                    end
                    `COR_SENSE_ADDR: begin
                        bus.rdata[`COR_SENSE_HALF_BIT] <= sense_half_q;
                    end
                    default: begin
                        bus.rdata <= `COR_WORD_ZERO;
                    end
                endcase
            end
        end
    end
endmodule // cor_device

// file: verilog/cor_host.sv
`include "cor_map.svh"

module cor_host (
    input wire logic ref_clk,
    input wire logic rst_n,
    cor_reg_if.host bus,
    input cor_pkg::cor_sw_addr_type sw_addr,
    input cor_pkg::cor_word_type sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output cor_pkg::cor_word_type sw_rdata
);
    import cor_pkg::*;

    function automatic logic sw_hit(input logic strobe, input cor_sw_addr_type a,
                                    input cor_sw_addr_type key);
        return strobe && (a == key);
    endfunction

    cor_state_type state_q;
    cor_addr_type target_q;
    cor_word_type data_q;
    cor_word_type result_q;
    logic go;

    assign go = sw_hit(sw_wr, sw_addr, `COR_H_GO) && (state_q == COR_IDLE);

    // ****************************************
    // Software-written staging registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_q <= '0;
            data_q <= `COR_WORD_ZERO;
        end else begin
            if (sw_hit(sw_wr, sw_addr, `COR_H_TARGET)) begin
                target_q <= sw_wdata[7:0];
            end
            if (sw_hit(sw_wr, sw_addr, `COR_H_DATA)) begin
                data_q <= sw_wdata;
            end
        end
    end

    // ****************************************
    // Transaction sequencer
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= COR_IDLE;
        end else begin
            case (state_q)
                COR_IDLE: begin
                    if (go) begin
                        state_q <= COR_ISSUE;
                    end
                end
                COR_ISSUE: begin
                    state_q <= bus.rd ? COR_CAPTURE : COR_IDLE;
                end
                COR_CAPTURE: begin
                    state_q <= COR_IDLE;
                end
                default: begin
                    state_q <= COR_IDLE;
                end
            endcase
        end
    end

    // Writes are relayed verbatim; clearing latches and bits is software's job
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.addr <= '0;
            bus.wdata <= `COR_WORD_ZERO;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
        end else if (go) begin
            bus.addr <= target_q;
            bus.wdata <= data_q;
            bus.wr <= !sw_wdata[`COR_H_GO_READ_BIT];
            bus.rd <= sw_wdata[`COR_H_GO_READ_BIT];
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= `COR_WORD_ZERO;
        end else if (state_q == COR_CAPTURE) begin
            result_q <= bus.rdata;
        end
    end

    // ****************************************
    // Software read port
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_rdata <= `COR_WORD_ZERO;
        end else if (sw_rd) begin
            case (sw_addr)
                `COR_H_TARGET: sw_rdata <= {8'h00, target_q};
                `COR_H_DATA: sw_rdata <= data_q;
                `COR_H_STATUS: sw_rdata <= {15'h0000, state_q != COR_IDLE};
                `COR_H_RESULT: sw_rdata <= result_q;
                default: sw_rdata <= `COR_WORD_ZERO;
            endcase
        end else begin
            sw_rdata <= `COR_WORD_ZERO;
        end
    end
endmodule // cor_host
